// >>> verilog/rld_regs.sv
// Control register bank of an RGB backlight LED driver with PWM
// period timing and drive selection for the current sinks and boost.
// Assumes a same-clock register master and an asynchronous dim pin.
//
// Summary of operation
// - Top two channel bits pick overlap or sequential 2, 3, 4 pulses.
// - Channel bit 5 enables automatic fade; resets to zero.
// - Channel bit 4 picks 1.22 kHz or 19.52 kHz PWM; resets to one.
// - Channel bit 3 enables temperature compensation; resets to zero.
// - Channel bits 0 to 2 enable red, green, blue outputs; reset zero.
// - Each colour has an 8-bit linear drive code, 0.234 mA per step.
// - Drive codes reset to 55 hex, about 20 mA.
// - Override clear takes brightness from pin; set from dim code.
// - Three-bit dim code gives a multiplier doubling per step.
// - Boost code bits 4 to 0 set 5 V to 20 V in 1 V steps.
// - System bit 5 picks external sensor or red LED voltage.
// - System bit 4 picks first or second sensor input.
// - System bit 3 controls the boost dummy loader.
// - System bit 2 picks manual or adaptive boost; resets to one.
// - System bit 1 enables the boost converter; resets to zero.
// - System bit 0 clear keeps the device in standby; resets zero.
// - With compensation on, drive codes come from calibration memory.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module rld_regs #(
  parameter int SLOW_DIV = rld_pkg::PWM_SLOW_CYC,
  parameter int FAST_DIV = rld_pkg::PWM_FAST_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_dim_pin,
  input wire logic [7:0] cal_red_code,
  input wire logic [7:0] cal_green_code,
  input wire logic [7:0] cal_blue_code,
  output logic led_en_red,
  output logic led_en_green,
  output logic led_en_blue,
  output logic [7:0] red_drive_code,
  output logic [7:0] green_drive_code,
  output logic [7:0] blue_drive_code,
  output logic [7:0] dim_mult,
  output logic fade_en,
  output logic comp_en,
  output logic temp_ref_sel,
  output logic sense_source_sel,
  output logic dummy_load_en,
  output logic boost_en,
  output logic boost_auto,
  output logic [4:0] boost_target,
  output logic pwm_fast,
  output logic pwm_period_tick,
  output logic [1:0] pwm_slot,
  output logic device_active
);

  localparam int DIV_W = $clog2(SLOW_DIV + 1);

  // Counter width follows the slow divider; fast must fit under it
  generate
    if (SLOW_DIV < 2 || FAST_DIV < 2 || FAST_DIV > SLOW_DIV) begin : g_chk
      $error("rld_regs: PWM dividers out of range");
    end
  endgenerate

  // Address match used by every write and by the read mux
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic [7:0] chan_r;
  logic [7:0] dim_r;
  logic [7:0] boost_r;
  logic [7:0] sys_r;
  logic [7:0] drv_r [3];
  logic [7:0] cal_code [3];
  logic [7:0] drv_out_r [3];
  logic en_out_r [3];
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic dim_s1_r;
  logic dim_s2_r;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_lim;
  logic tick_r;
  logic [1:0] slot_r;
  logic [7:0] dim_out_r;
  logic [4:0] boost_out_r;
  logic active;
  logic [1:0] seq_mode;

  assign active = sys_r[rld_pkg::SYS_ACTIVE];
  assign seq_mode = chan_r[rld_pkg::CH_SEQ_LSB +: 2];
  assign cal_code[0] = cal_red_code;
  assign cal_code[1] = cal_green_code;
  assign cal_code[2] = cal_blue_code;

  // Channel control, only writable bits follow the write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chan_r <= rld_pkg::RST_CHAN_CTRL;
    end else if (reg_wr && hit(reg_addr, rld_pkg::OFF_CHAN_CTRL)) begin
      chan_r <= reg_wdata & rld_pkg::WM_CHAN_CTRL;
    end
  end

  // Dimming level; upper bits stay zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dim_r <= rld_pkg::RST_DIM;
    end else if (reg_wr && hit(reg_addr, rld_pkg::OFF_DIM)) begin
      dim_r <= reg_wdata & rld_pkg::WM_DIM;
    end
  end

  // Boost voltage code; out-of-range codes are kept for readback
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      boost_r <= rld_pkg::RST_BOOST;
    end else if (reg_wr && hit(reg_addr, rld_pkg::OFF_BOOST)) begin
      boost_r <= reg_wdata & rld_pkg::WM_BOOST;
    end
  end

  // System control
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sys_r <= rld_pkg::RST_SYS_CTRL;
    end else if (reg_wr && hit(reg_addr, rld_pkg::OFF_SYS_CTRL)) begin
      sys_r <= reg_wdata & rld_pkg::WM_SYS_CTRL;
    end
  end

  // One drive code register and one sink code per colour
  generate
    for (genvar c = 0; c < 3; c++) begin : g_col
      localparam logic [7:0] OFF = rld_pkg::OFF_RED_DRV + 8'(c);

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          drv_r[c] <= rld_pkg::RST_DRV;
        end else if (reg_wr && hit(reg_addr, OFF)) begin
          drv_r[c] <= reg_wdata & rld_pkg::WM_DRV;
        end
      end

      // Calibration data replaces the code under compensation
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          drv_out_r[c] <= rld_pkg::RST_DRV;
        end else if (chan_r[rld_pkg::CH_AUTO_COMP]) begin
          drv_out_r[c] <= cal_code[c];
        end else begin
          drv_out_r[c] <= drv_r[c];
        end
      end

      // Outputs stay off in standby whatever the enables say
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          en_out_r[c] <= 1'b0;
        end else begin
          en_out_r[c] <= chan_r[rld_pkg::CH_EN_RED + c] && active;
        end
      end
    end
  endgenerate

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(reg_addr, rld_pkg::OFF_CHAN_CTRL)) begin
      rdata_nxt = chan_r;
    end else if (hit(reg_addr, rld_pkg::OFF_RED_DRV)) begin
      rdata_nxt = drv_r[0];
    end else if (hit(reg_addr, rld_pkg::OFF_GREEN_DRV)) begin
      rdata_nxt = drv_r[1];
    end else if (hit(reg_addr, rld_pkg::OFF_BLUE_DRV)) begin
      rdata_nxt = drv_r[2];
    end else if (hit(reg_addr, rld_pkg::OFF_DIM)) begin
      rdata_nxt = dim_r;
    end else if (hit(reg_addr, rld_pkg::OFF_BOOST)) begin
      rdata_nxt = boost_r;
    end else if (hit(reg_addr, rld_pkg::OFF_SYS_CTRL)) begin
      rdata_nxt = sys_r;
    end else if (hit(reg_addr, rld_pkg::OFF_STATUS)) begin
      rdata_nxt = {3'h0, dim_s2_r, tick_r, slot_r, active};
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // Dim pin is asynchronous: two flops before any use
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dim_s1_r <= 1'b0;
      dim_s2_r <= 1'b0;
    end else begin
      dim_s1_r <= ext_dim_pin;
      dim_s2_r <= dim_s1_r;
    end
  end

  // Multiplier in 1/128 units: code 7 is 1.000, code 0 is 1/128
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dim_out_r <= 8'h00;
    end else if (dim_r[rld_pkg::DIM_OVERRIDE]) begin
      dim_out_r <= 8'h01 << dim_r[rld_pkg::DIM_CODE_LSB +: 3];
    end else if (dim_s2_r) begin
      dim_out_r <= rld_pkg::DIM_FULL;
    end else begin
      dim_out_r <= 8'h00;
    end
  end

  // Manual target clamped into the documented 5 V to 20 V span
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      boost_out_r <= rld_pkg::BOOST_MIN;
    end else if (boost_r[4:0] < rld_pkg::BOOST_MIN) begin
      boost_out_r <= rld_pkg::BOOST_MIN;
    end else if (boost_r[4:0] > rld_pkg::BOOST_MAX) begin
      boost_out_r <= rld_pkg::BOOST_MAX;
    end else begin
      boost_out_r <= boost_r[4:0];
    end
  end

  // Period limit follows the rate bit live
  assign div_lim = chan_r[rld_pkg::CH_PWM_FAST]
                 ? DIV_W'(FAST_DIV - 1)
                 : DIV_W'(SLOW_DIV - 1);

  // PWM period counter; held in standby. A >= compare lets a switch
  // to the fast rate wrap at once rather than run a long period.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else if (!active) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else if (div_r >= div_lim) begin
      div_r <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // Pulse slot: one colour per period in sequential modes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      slot_r <= 2'h0;
    end else begin
      case (rld_pkg::rld_seq_t'(seq_mode))
        rld_pkg::SEQ_OVERLAP: begin
          slot_r <= 2'h0;
        end
        rld_pkg::SEQ_TWO, rld_pkg::SEQ_THREE,
        rld_pkg::SEQ_FOUR: begin
          // Each slot lasts a whole period; wrap on a tick, or at once if the slot is above the mode
          if (!active) begin
            slot_r <= 2'h0;
          end else if (slot_r > seq_mode) begin
            slot_r <= 2'h0;
          end else if (tick_r && slot_r == seq_mode) begin
            slot_r <= 2'h0;
          end else if (tick_r) begin
            slot_r <= slot_r + 2'h1;
          end
        end
        default: begin
          slot_r <= 2'h0;
        end
      endcase
    end
  end

  // Flag fields straight from chan_r and sys_r, the rest from their output flops; boost_en is also gated by active
  assign reg_rdata = rdata_r;
  assign led_en_red = en_out_r[0];
  assign led_en_green = en_out_r[1];
  assign led_en_blue = en_out_r[2];
  assign red_drive_code = drv_out_r[0];
  assign green_drive_code = drv_out_r[1];
  assign blue_drive_code = drv_out_r[2];
  assign dim_mult = dim_out_r;
  assign fade_en = chan_r[rld_pkg::CH_FADE];
  assign comp_en = chan_r[rld_pkg::CH_AUTO_COMP];
  assign pwm_fast = chan_r[rld_pkg::CH_PWM_FAST];
  assign temp_ref_sel = sys_r[rld_pkg::SYS_TEMP_REF];
  assign sense_source_sel = sys_r[rld_pkg::SYS_SENSE_SEL];
  assign dummy_load_en = sys_r[rld_pkg::SYS_DUMMY_LOAD];
  assign boost_auto = sys_r[rld_pkg::SYS_BOOST_AUTO];
  assign boost_en = sys_r[rld_pkg::SYS_BOOST_EN] && active;
  assign boost_target = boost_out_r;
  assign pwm_period_tick = tick_r;
  assign pwm_slot = slot_r;
  assign device_active = active;

endmodule : rld_regs

// >>> common/rld_pkg.sv
// Register map, field layout, reset values and timing of the RGB LED
// driver control bank. Shared by the design and the bench.
package rld_pkg;

  // Register offsets (byte addresses of an 8-bit register port)
  localparam logic [7:0] OFF_CHAN_CTRL = 8'h00;
  localparam logic [7:0] OFF_RED_DRV = 8'h01;
  localparam logic [7:0] OFF_GREEN_DRV = 8'h02;
  localparam logic [7:0] OFF_BLUE_DRV = 8'h03;
  localparam logic [7:0] OFF_DIM = 8'h04;
  localparam logic [7:0] OFF_BOOST = 8'h05;
  localparam logic [7:0] OFF_SYS_CTRL = 8'h06;
  localparam logic [7:0] OFF_STATUS = 8'h07;

  // Channel control fields
  localparam int CH_SEQ_LSB = 6;
  localparam int CH_FADE = 5;
  localparam int CH_PWM_FAST = 4;
  localparam int CH_AUTO_COMP = 3;
  localparam int CH_EN_BLUE = 2;
  localparam int CH_EN_GREEN = 1;
  localparam int CH_EN_RED = 0;

  // Dimming level fields
  localparam int DIM_OVERRIDE = 3;
  localparam int DIM_CODE_LSB = 0;

  // System control fields
  localparam int SYS_TEMP_REF = 5;
  localparam int SYS_SENSE_SEL = 4;
  localparam int SYS_DUMMY_LOAD = 3;
  localparam int SYS_BOOST_AUTO = 2;
  localparam int SYS_BOOST_EN = 1;
  localparam int SYS_ACTIVE = 0;

  // Reset values
  localparam logic [7:0] RST_CHAN_CTRL = 8'h10;
  localparam logic [7:0] RST_DRV = 8'h55;
  localparam logic [7:0] RST_DIM = 8'h00;
  localparam logic [7:0] RST_BOOST = 8'h00;
  localparam logic [7:0] RST_SYS_CTRL = 8'h04;

  // Writable bits; all others are read-only zero
  localparam logic [7:0] WM_CHAN_CTRL = 8'hFF;
  localparam logic [7:0] WM_DRV = 8'hFF;
  localparam logic [7:0] WM_DIM = 8'h0F;
  localparam logic [7:0] WM_BOOST = 8'h1F;
  localparam logic [7:0] WM_SYS_CTRL = 8'h3F;

  // Boost target code range, 1 V per step
  localparam logic [4:0] BOOST_MIN = 5'h05;
  localparam logic [4:0] BOOST_MAX = 5'h14;

  // Dim multiplier of one, in 1/128 units
  localparam logic [7:0] DIM_FULL = 8'h80;

  // PWM rates and clock
  localparam int CLK_HZ = 125_000_000;
  localparam int PWM_SLOW_HZ = 1220;
  localparam int PWM_FAST_HZ = 19520;
  localparam int PWM_SLOW_CYC = CLK_HZ / PWM_SLOW_HZ;
  localparam int PWM_FAST_CYC = CLK_HZ / PWM_FAST_HZ;

  // Pulse ordering modes
  typedef enum logic [1:0] {
    SEQ_OVERLAP,
    SEQ_TWO,
    SEQ_THREE,
    SEQ_FOUR
  } rld_seq_t;

endpackage : rld_pkg

// >>> bench/rld_regs_properties.sv
// Checker of the LED driver register bank, on top-level ports only.
// Assumes one clock domain and a reset that loads every register.
`timescale 1ns/100ps
module rld_regs_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] cal_red_code,
  input wire logic led_en_red,
  input wire logic [7:0] red_drive_code,
  input wire logic [7:0] dim_mult,
  input wire logic fade_en,
  input wire logic comp_en,
  input wire logic boost_en,
  input wire logic [4:0] boost_target,
  input wire logic pwm_fast,
  input wire logic device_active
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Strobes at one offset
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence

  // Out-of-range codes never reach the converter
  function automatic logic [4:0] clamp(input logic [4:0] v);
    return v < rld_pkg::BOOST_MIN ? rld_pkg::BOOST_MIN :
      (v > rld_pkg::BOOST_MAX ? rld_pkg::BOOST_MAX : v);
  endfunction : clamp

  a_fade_follows: assert property (
    s_wr(rld_pkg::OFF_CHAN_CTRL) |=>
    fade_en == $past(reg_wdata[rld_pkg::CH_FADE])) else $error("fade bit");
  a_rate_follows: assert property (
    s_wr(rld_pkg::OFF_CHAN_CTRL) |=>
    pwm_fast == $past(reg_wdata[rld_pkg::CH_PWM_FAST])) else $error("rate");
  a_red_enable: assert property (
    s_wr(rld_pkg::OFF_CHAN_CTRL) |=> ##1
    led_en_red == ($past(reg_wdata[0], 2) && $past(device_active)))
    else $error("red enable");
  a_standby_dark: assert property (
    !device_active |=> !led_en_red) else $error("led on in standby");
  a_boost_gate: assert property (
    boost_en |-> device_active) else $error("boost on in standby");
  a_boost_clamp: assert property (
    s_wr(rld_pkg::OFF_BOOST) |=> ##1
    boost_target == clamp($past(reg_wdata[4:0], 2))) else $error("boost");
  a_drive_code: assert property (
    s_wr(rld_pkg::OFF_RED_DRV) ##0 !comp_en |=> ##1
    red_drive_code == $past(reg_wdata, 2)) else $error("drive code");
  a_cal_source: assert property (
    comp_en |=> red_drive_code == $past(cal_red_code))
    else $error("cal code");
  a_dim_code: assert property (
    s_wr(rld_pkg::OFF_DIM) ##0 reg_wdata[rld_pkg::DIM_OVERRIDE] |=> ##1
    dim_mult == (8'h01 << $past(reg_wdata[2:0], 2))) else $error("dim");
  a_ro_zero: assert property (
    s_rd(rld_pkg::OFF_SYS_CTRL) |=> reg_rdata[7:6] == 2'h0)
    else $error("read-only bits");
endmodule : rld_regs_properties

bind rld_regs rld_regs_properties i_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cal_red_code(cal_red_code),
  .led_en_red(led_en_red), .red_drive_code(red_drive_code),
  .dim_mult(dim_mult), .fade_en(fade_en), .comp_en(comp_en),
  .boost_en(boost_en), .boost_target(boost_target), .pwm_fast(pwm_fast),
  .device_active(device_active)
);

// >>> bench/rld_sink_model.sv
// Behavioural red current sink and calibration store on the far side.
// Assumes drive codes and enables come straight from the bank.
`timescale 1ns/100ps
module rld_sink_model #(
  parameter logic [7:0] CAL_R = 8'h3C,
  parameter logic [7:0] CAL_G = 8'h4B,
  parameter logic [7:0] CAL_B = 8'h5A
) (
  input wire logic led_en_red,
  input wire logic [7:0] red_drive_code,
  output logic [15:0] red_sink_ua,
  output logic [7:0] cal_red_code,
  output logic [7:0] cal_green_code,
  output logic [7:0] cal_blue_code
);
  // Linear sink, 234 uA a step; dark when the output is off
  assign red_sink_ua = led_en_red ?
    16'(red_drive_code) * 16'h00EA : 16'h0000;
  // Fixed calibration codes, so compensation is easy to spot
  assign cal_red_code = CAL_R;
  assign cal_green_code = CAL_G;
  assign cal_blue_code = CAL_B;
endmodule : rld_sink_model

// >>> bench/test_rgb_led_driver_control_regs.sv
// Self-checking bench of the LED driver register bank: table of writes
// and readbacks, then dimming, PWM, compensation and reset cases.
// Assumes short PWM divisors so each period takes a few cycles.
`timescale 1ns/100ps
module test_rgb_led_driver_control_regs;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} rld_row_t;
  localparam int SLOW = 40;
  localparam int FAST = 8;
  logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic ext_dim_pin = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
  logic [7:0] cal_r, cal_g, cal_b, red_code, grn_code, blu_code, dim_mult;
  logic led_r, led_g, led_b, fade_en, comp_en, temp_ref, sense_sel, dummy;
  logic boost_en, boost_auto, pwm_fast, tick, dev_active;
  logic [4:0] boost_target;
  logic [1:0] slot, prev;
  logic [15:0] red_ua;
  int errors = 0, cmp_count = 0, cyc = 0, n = 0;
  // Offset 0x08 is unmapped and must read zero
  rld_row_t rows [8] = '{'{8'h00, 8'hC5, 8'hC5}, '{8'h01, 8'hFF, 8'hFF},
    '{8'h02, 8'h00, 8'h00}, '{8'h03, 8'hA3, 8'hA3}, '{8'h04, 8'hFF, 8'h0F},
    '{8'h05, 8'hFF, 8'h1F}, '{8'h06, 8'hFF, 8'h3F}, '{8'h08, 8'h5A, 8'h00}};
  // Last entry is the status offset, idle after reset
  logic [7:0] rst_val [8] = '{8'h10, 8'h55, 8'h55, 8'h55, 8'h00, 8'h00,
    8'h04, 8'h00};

  always #4 clk_sys = ~clk_sys;

  rld_regs #(.SLOW_DIV(SLOW), .FAST_DIV(FAST)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_dim_pin(ext_dim_pin),
    .cal_red_code(cal_r), .cal_green_code(cal_g), .cal_blue_code(cal_b),
    .led_en_red(led_r), .led_en_green(led_g), .led_en_blue(led_b),
    .red_drive_code(red_code), .green_drive_code(grn_code),
    .blue_drive_code(blu_code), .dim_mult(dim_mult), .fade_en(fade_en),
    .comp_en(comp_en), .temp_ref_sel(temp_ref),
    .sense_source_sel(sense_sel), .dummy_load_en(dummy),
    .boost_en(boost_en), .boost_auto(boost_auto),
    .boost_target(boost_target), .pwm_fast(pwm_fast),
    .pwm_period_tick(tick), .pwm_slot(slot), .device_active(dev_active)
  );

  rld_sink_model i_sink (
    .led_en_red(led_r), .red_drive_code(red_code), .red_sink_ua(red_ua),
    .cal_red_code(cal_r), .cal_green_code(cal_g), .cal_blue_code(cal_b)
  );

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t current %h want %h", $time, got, exp);
    end
  endtask : chk16

  // Strobes go up one edge and down the next, so calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : settle

  // Edges until the next period tick, bounded
  task automatic wait_tick();
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (tick !== 1'b1 && n < 200);
  endtask : wait_tick

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk8(rd_val, rows[i].e);
    end
    settle(2);
    chk8({2'h0, temp_ref, sense_sel, dummy, boost_auto, boost_en,
      dev_active}, 8'h3F);
    chk8({5'h00, led_b, led_g, led_r}, 8'h05);
    chk16(red_ua, 16'hE916);
    chk8({3'h0, boost_target}, 8'h14);
    chk8(grn_code, 8'h00);
    chk8(blu_code, 8'hA3);
    chk8({5'h00, fade_en, comp_en, pwm_fast}, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(rld_pkg::OFF_DIM, 8'h08 | 8'(c));
      settle(2);
      chk8(dim_mult, 8'h01 << c);
    end
    // Pin mode: two sync flops plus one register stage
    wr(rld_pkg::OFF_DIM, 8'h07);
    @(posedge clk_sys);
    ext_dim_pin <= 1'b1;
    settle(4);
    chk8(dim_mult, rld_pkg::DIM_FULL);
    @(posedge clk_sys);
    ext_dim_pin <= 1'b0;
    settle(4);
    chk8(dim_mult, 8'h00);
    // Every ordering mode; slot must step on each tick and wrap, or stay 0 in overlap
    for (int m = 0; m < 4; m++) begin
      wr(rld_pkg::OFF_CHAN_CTRL, {2'(m), 6'h30});
      wait_tick();
      settle(2);
      chk8({6'h00, fade_en, pwm_fast}, 8'h03);
      prev = slot;
      for (int k = 0; k < 5; k++) begin
        wait_tick();
        chk8(8'(n), 8'(FAST - 2));
        settle(2);
        chk8({6'h00, slot}, m == 0 ? 8'h00 : 8'((prev + 1) % (m + 1)));
        prev = slot;
      end
    end
    wr(rld_pkg::OFF_CHAN_CTRL, 8'h00);
    wait_tick();
    wait_tick();
    chk8(8'(n), 8'(SLOW));
    wr(rld_pkg::OFF_CHAN_CTRL, 8'h09);
    settle(2);
    chk8(red_code, 8'h3C);
    chk8(grn_code, 8'h4B);
    chk8(blu_code, 8'h5A);
    chk8({7'h00, comp_en}, 8'h01);
    wr(rld_pkg::OFF_BOOST, 8'h02);
    wr(rld_pkg::OFF_SYS_CTRL, 8'h02);
    settle(2);
    chk8({3'h0, boost_target}, 8'h05);
    chk8({6'h00, boost_en, led_r}, 8'h00);
    // Mid-run reset must restore every documented value
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (rst_val[i]) begin
      rd(8'(i));
      chk8(rd_val, rst_val[i]);
    end
    chk8(red_code, 8'h55);
    chk8(grn_code, 8'h55);
    chk8(blu_code, 8'h55);
    chk8({2'h0, temp_ref, sense_sel, dummy, boost_auto, boost_en,
      dev_active}, 8'h04);
    chk8({5'h00, fade_en, comp_en, pwm_fast}, 8'h01);
    close_out();
  end
endmodule : test_rgb_led_driver_control_regs
